/* File: rtl/temp_adc_pkg.sv */
// Package: constants and types for the temperature converter sequencer.
// Assumes a 50 MHz system clock.
package temp_adc_pkg;

    // ========================================
    // Clock and timing
    // ========================================
    localparam int CLK_MHZ           = 50;
    localparam int HOLD_DELAY_NS     = 3000;
    localparam int CONV_ADC_NS       = 15000;
    localparam int CONV_TEMP_NS      = 30000;
    localparam int AUTO_PERIOD_US    = 355;
    localparam int HOLD_DELAY_CYC    = (HOLD_DELAY_NS * CLK_MHZ) / 1000;
    localparam int CONV_ADC_CYC      = (CONV_ADC_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_TEMP_CYC     = (CONV_TEMP_NS * CLK_MHZ + 999) / 1000;
    localparam int AUTO_PERIOD_CYC   = AUTO_PERIOD_US * CLK_MHZ;
    localparam int CNT_W             = 15;

    // ========================================
    // Register map
    // ========================================
    localparam logic [2:0] ADDR_TEMP    = 3'h0;
    localparam logic [2:0] ADDR_CONFIG  = 3'h1;
    localparam logic [2:0] ADDR_HYST    = 3'h2;
    localparam logic [2:0] ADDR_OTI     = 3'h3;
    localparam logic [2:0] ADDR_ADC     = 3'h4;
    localparam logic [2:0] ADDR_SECOND_CONFIGURATION = 3'h5;
    localparam int         SEL_LSB      = 0;
    localparam int         SEL_W        = 3;
    localparam int         CH_LSB       = 5;
    localparam int         MODE_BIT     = 7;
    localparam int         RES_LSB      = 6;
    localparam logic [2:0] CH_TEMP      = 3'h0;
    localparam logic [7:0] CONFIG_RST   = 8'h00;
    localparam logic [7:0] SECOND_CONFIGURATION_RST  = 8'h00;
    localparam logic [7:0] SECOND_CONFIGURATION_MASK = 8'hC0;
    localparam logic [15:0] SETP_MASK   = 16'hFF80;
    localparam logic [15:0] HYST_RST    = 16'h0000;
    localparam logic [15:0] OTI_RST     = 16'h0000;
    localparam logic [7:0] PTR_RST      = 8'h00;

    // ========================================
    // Types
    // ========================================
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_CONV} seq_state_t;

    typedef struct packed {
        logic       start;
        logic       first;
        logic [7:0] data;
    } wr_byte_t;

    typedef struct packed {
        logic       busy;
        logic       hold;
        logic       ref_on;
    } analog_ctl_t;

endpackage : temp_adc_pkg

/* File: rtl/temp_adc_seq.sv */
// Conversion sequencer, result store and register pointer.
// Assumes a protocol engine on clk_i delivers decoded bus bytes and
// transfer boundaries; convert_strobe_n_i is an asynchronous pin.
// Notes on behaviour
// (R1) Strobe falling edge: hold, start conversion
// (R2) Conversion timing from internal clock
// (R3) Auto mode: each bus transfer restarts conversion
// (R4) Hold about 3 us after transfer
// (R5) Result after 15 us, temperature 30 us
// (R6) Host waits 400 ns acquisition
// (R7) Channel 0 conversion gives temperature
// (R8) Temperature is 10-bit two's complement
// (R9) Temperature stored in upper bits of 00h
// (R10) Host converts code to degrees
// (R11) First write byte loads pointer
// (R12) Only three pointer bits select register
// (R13) Host writes zero to upper pointer
// (R14) Select field maps six registers
// (R15) Reference amplifier on only during conversion
// (R16) Bus traffic aborts and restarts conversion
// (R17) Config bits 7..5 select channel
// (R18) Second_configuration top bit: auto 355 us or strobe
// (R19) Pointer kept between transactions
`timescale 1ns/10ps
`default_nettype none
module temp_adc_seq
    import temp_adc_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Convert strobe pin
    input  wire logic        convert_strobe_n_i,
    // Bus side from protocol engine
    input  wire logic        bus_active_i,
    input  wire logic        bus_done_i,
    input  wire wr_byte_t    wr_byte_i,
    input  wire logic        rd_next_i,
    output logic [7:0]       rd_data_o,
    // Converter core
    input  wire logic        adc_valid_i,
    input  wire logic [9:0]  adc_code_i,
    output analog_ctl_t      analog_o,
    output logic [2:0]       channel_o,
    // Status
    output logic [7:0]       pointer_o,
    output logic [7:0]       config_o,
    output logic [15:0]      hyst_o,
    output logic [15:0]      oti_o
);
    // ========================================
    // Register decode
    // ========================================
    function automatic logic [2:0] sel_of(input logic [7:0] p);
        sel_of = p[SEL_LSB +: SEL_W]; // R12
    endfunction : sel_of

    // ========================================
    // Strobe synchroniser
    // ========================================
    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            strobe_meta <= 1'b1;
            strobe_sync <= 1'b1;
            strobe_prev <= 1'b1;
        end
        else if (ce_i)
        begin
            strobe_meta <= convert_strobe_n_i;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
        end
    end

    logic strobe_fall;
    assign strobe_fall = strobe_prev && !strobe_sync;

    // ========================================
    // Registers
    // ========================================
    logic [7:0]  pointer;
    logic [7:0]  cfg;
    logic [7:0]  cfg2;
    logic [15:0] hyst;
    logic [15:0] oti;
    logic [15:0] temp_word;
    logic [15:0] adc_word;
    logic        byte_hi;
    logic [7:0]  next_pointer;
    logic [7:0]  next_cfg;
    logic [7:0]  next_cfg2;
    logic [15:0] next_hyst;
    logic [15:0] next_oti;
    logic [15:0] next_temp_word;
    logic [15:0] next_adc_word;
    logic        next_byte_hi;
    logic [2:0]  conv_ch;

    always_comb
    begin
        next_pointer   = pointer;
        next_cfg       = cfg;
        next_cfg2      = cfg2;
        next_hyst      = hyst;
        next_oti       = oti;
        next_temp_word = temp_word;
        next_adc_word  = adc_word;
        next_byte_hi   = byte_hi;
        if (bus_done_i)
            next_byte_hi = 1'b0;
        if (wr_byte_i.start)
        begin
            if (wr_byte_i.first)
            begin
                next_pointer = wr_byte_i.data; // R11
                next_byte_hi = 1'b0;
            end
            else
            begin
                case (sel_of(pointer)) // R14
                    ADDR_CONFIG:  next_cfg = wr_byte_i.data;
                    ADDR_SECOND_CONFIGURATION: next_cfg2 = wr_byte_i.data & SECOND_CONFIGURATION_MASK;
                    ADDR_HYST:
                    begin
                        if (!byte_hi)
                            next_hyst[15:8] = wr_byte_i.data;
                        else
                            next_hyst[7:0] = wr_byte_i.data & SETP_MASK[7:0];
                    end
                    ADDR_OTI:
                    begin
                        if (!byte_hi)
                            next_oti[15:8] = wr_byte_i.data;
                        else
                            next_oti[7:0] = wr_byte_i.data & SETP_MASK[7:0];
                    end
                    default: next_cfg = cfg;
                endcase
                next_byte_hi = !byte_hi;
            end
        end
        else if (rd_next_i)
            next_byte_hi = !byte_hi;
        if (adc_valid_i)
        begin
            if (conv_ch == CH_TEMP)
                next_temp_word = {adc_code_i, 6'h00}; // R7 R8 R9
            else
                next_adc_word = {adc_code_i, 6'h00};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pointer   <= PTR_RST;
            cfg       <= CONFIG_RST;
            cfg2      <= SECOND_CONFIGURATION_RST;
            hyst      <= HYST_RST;
            oti       <= OTI_RST;
            temp_word <= 16'h0000;
            adc_word  <= 16'h0000;
            byte_hi   <= 1'b0;
        end
        else if (ce_i)
        begin
            pointer   <= next_pointer; // R19
            cfg       <= next_cfg;
            cfg2      <= next_cfg2;
            hyst      <= next_hyst;
            oti       <= next_oti;
            temp_word <= next_temp_word;
            adc_word  <= next_adc_word;
            byte_hi   <= next_byte_hi;
        end
    end

    // ========================================
    // Read mux
    // ========================================
    logic [15:0] rd_word;

    always_comb
    begin
        case (sel_of(pointer)) // R14
            ADDR_TEMP:    rd_word = temp_word;
            ADDR_CONFIG:  rd_word = {cfg, 8'h00};
            ADDR_HYST:    rd_word = hyst;
            ADDR_OTI:     rd_word = oti;
            ADDR_ADC:     rd_word = adc_word;
            ADDR_SECOND_CONFIGURATION: rd_word = {cfg2, 8'h00};
            default:      rd_word = 16'h0000;
        endcase
    end

    logic [7:0] rd_data;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            rd_data <= 8'h00;
        else if (ce_i)
            rd_data <= byte_hi ? rd_word[7:0] : rd_word[15:8];
    end

    // ========================================
    // Conversion sequencer
    // ========================================
    seq_state_t       state;
    seq_state_t       next_state;
    logic [2:0]       next_conv_ch;
    logic             tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic             tmr_done;
    logic             auto_mode;
    logic             in_conv;

    assign auto_mode = !cfg2[MODE_BIT]; // R18

    always_comb
    begin
        next_state   = state;
        next_conv_ch = conv_ch;
        tmr_load     = 1'b0;
        tmr_value    = '0;
        in_conv      = 1'b0;
        case (state)
            SEQ_IDLE:
            begin
                if (auto_mode && tmr_done && !bus_active_i)
                begin
                    next_state   = SEQ_CONV; // R18
                    next_conv_ch = cfg[CH_LSB +: 3];
                    tmr_load     = 1'b1;
                    tmr_value    = (cfg[CH_LSB +: 3] == CH_TEMP) ?
                                   CNT_W'(CONV_TEMP_CYC) : CNT_W'(CONV_ADC_CYC); // R5
                end
            end
            SEQ_WAIT:
            begin
                if (tmr_done)
                begin
                    next_state   = SEQ_CONV; // R4
                    next_conv_ch = cfg[CH_LSB +: 3]; // R17
                    tmr_load     = 1'b1;
                    tmr_value    = (cfg[CH_LSB +: 3] == CH_TEMP) ?
                                   CNT_W'(CONV_TEMP_CYC) : CNT_W'(CONV_ADC_CYC); // R5
                end
            end
            SEQ_CONV:
            begin
                in_conv = 1'b1;
                if (tmr_done)
                begin
                    next_state = SEQ_IDLE;
                    tmr_load   = auto_mode;
                    tmr_value  = CNT_W'(AUTO_PERIOD_CYC);
                end
            end
            default: next_state = SEQ_IDLE;
        endcase
        if (bus_active_i && state != SEQ_IDLE)
        begin
            next_state = SEQ_WAIT; // R16
            tmr_load   = 1'b1;
            tmr_value  = '0;
        end
        if (bus_done_i && (auto_mode || state == SEQ_WAIT))
        begin
            next_state = SEQ_WAIT; // R3 R16
            tmr_load   = 1'b1;
            tmr_value  = CNT_W'(HOLD_DELAY_CYC);
        end
        else if (strobe_fall && !bus_active_i)
        begin
            next_state   = SEQ_CONV; // R1
            next_conv_ch = cfg[CH_LSB +: 3];
            tmr_load     = 1'b1;
            tmr_value    = (cfg[CH_LSB +: 3] == CH_TEMP) ?
                           CNT_W'(CONV_TEMP_CYC) : CNT_W'(CONV_ADC_CYC);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state   <= SEQ_IDLE;
            conv_ch <= CH_TEMP;
        end
        else if (ce_i)
        begin
            state   <= next_state;
            conv_ch <= next_conv_ch;
        end
    end

    temp_adc_timer u_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .load_i  (tmr_load),
        .value_i (tmr_value),
        .done_o  (tmr_done) // R2
    );

    // ========================================
    // Outputs
    // ========================================
    analog_ctl_t analog;
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            analog <= '0;
        else if (ce_i)
        begin
            analog.busy   <= (next_state != SEQ_IDLE);
            analog.hold   <= (next_state == SEQ_CONV); // R1 R4
            analog.ref_on <= (next_state == SEQ_CONV); // R15
        end
    end

    assign analog_o  = analog;
    assign channel_o = conv_ch;
    assign rd_data_o = rd_data;
    assign pointer_o = pointer;
    assign config_o  = cfg;
    assign hyst_o    = hyst;
    assign oti_o     = oti;

    logic unused_ok;
    assign unused_ok = in_conv;
endmodule : temp_adc_seq
`default_nettype wire

/* File: rtl/temp_adc_timer.sv */
// Down counter with load, used for all conversion timing.
// Assumes clk_i domain logic; counts only while ce_i is high.
`timescale 1ns/10ps
`default_nettype none
module temp_adc_timer
    import temp_adc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    // Control
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] value_i,
    output logic                  done_o
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (load_i)
            next_count = value_i;
        else if (count != '0)
            next_count = count - 1'b1;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            count <= '0;
        else if (ce_i)
            count <= next_count;
    end

    assign done_o = (count == 15'h0001);
endmodule : temp_adc_timer
`default_nettype wire

/* File: testbench/temp_adc_conversion_ptr_test.sv */
// Testbench for the conversion sequencer and register pointer.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end
module temp_adc_conversion_ptr_test
    import temp_adc_pkg::*;
;
    localparam int          DEG   = -25;
    localparam logic [9:0]  TCODE = 10'(DEG * 4);
    localparam logic [15:0] TEMP  = {TCODE, 6'h00};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        strobe_n;
    logic        bus_active;
    logic        bus_done;
    wr_byte_t    wr_byte;
    logic        rd_next;
    logic [7:0]  rd_data;
    logic        adc_valid;
    logic [9:0]  adc_code;
    analog_ctl_t analog;
    logic [2:0]  channel;
    logic [7:0]  pointer;
    logic [7:0]  cfg;
    logic [15:0] hyst;
    logic [15:0] oti;
    logic [7:0]  hi;
    logic [7:0]  lo;
    int          n_tests = 0;
    int          miscompares = 0;
    temp_adc_seq temp_adc_seq_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .convert_strobe_n_i(strobe_n),
        .bus_active_i(bus_active), .bus_done_i(bus_done), .wr_byte_i(wr_byte), .rd_next_i(rd_next),
        .rd_data_o(rd_data), .adc_valid_i(adc_valid), .adc_code_i(adc_code), .analog_o(analog),
        .channel_o(channel), .pointer_o(pointer), .config_o(cfg), .hyst_o(hyst), .oti_o(oti));
    temp_adc_host #(.CODE(TCODE)) temp_adc_host_i (.clk_i(clk_i), .analog_i(analog), .rd_data_i(rd_data),
        .bus_active_o(bus_active), .bus_done_o(bus_done), .wr_byte_o(wr_byte), .rd_next_o(rd_next),
        .strobe_n_o(strobe_n), .adc_valid_o(adc_valid), .adc_code_o(adc_code));
    always #10 clk_i = ~clk_i;
    task automatic complete_run();
        $display("Counts: %0d compares, %0d miscompares", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : complete_run
    task automatic fail();
        miscompares++;
        complete_run();
    endtask : fail
    task automatic wait_idle();
        for (int i = 0; i < 4000 && analog.busy !== 1'b0; i++)
            @(negedge clk_i);
        if (analog.busy !== 1'b0)
            fail();
    endtask : wait_idle
    task automatic wait_hold(input int lim);
        for (int i = 0; i < lim && analog.hold !== 1'b1; i++)
            @(negedge clk_i);
        if (analog.hold !== 1'b1)
            fail();
    endtask : wait_hold
    task automatic hold_len(output int n);
        for (n = 0; n < 2000 && analog.hold === 1'b1; n++)
            @(negedge clk_i);
        if (n == 2000)
            fail();
    endtask : hold_len
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        temp_adc_host_i.put(1'b1, p);
        temp_adc_host_i.put(1'b0, d);
        temp_adc_host_i.fin();
    endtask : wr
    task automatic rd(input logic [7:0] p);
        temp_adc_host_i.put(1'b1, p);
        temp_adc_host_i.fin();
        temp_adc_host_i.get(hi, lo);
        temp_adc_host_i.fin();
    endtask : rd
    task automatic t_auto();
        int n;
        temp_adc_host_i.put(1'b1, 8'h00);
        temp_adc_host_i.fin();
        @(negedge clk_i);
        `CHK(analog.busy, 1'b1)
        repeat (148) @(negedge clk_i);
        `CHK(analog.hold, 1'b0)
        @(negedge clk_i);
        `CHK(analog.hold, 1'b1)
        `CHK(analog.ref_on, 1'b1)
        hold_len(n);
        `CHK(n, CONV_TEMP_CYC)
        `CHK(analog.ref_on, 1'b0)
        rd(8'h00);
        `CHK({hi, lo}, TEMP)
        temp_adc_host_i.get(hi, lo);
        temp_adc_host_i.fin();
        `CHK(hi, TEMP[15:8])
        $display("t_auto finished");
    endtask : t_auto
    task automatic t_regs();
        `CHK({pointer, cfg, hyst}, {8'h00, CONFIG_RST, HYST_RST})
        wr(8'h01, 8'h20);
        `CHK({pointer, cfg}, 16'h0120)
        // Upper pointer bit set on purpose: selection must ignore it
        temp_adc_host_i.put(1'b1, 8'h0A);
        temp_adc_host_i.put(1'b0, 8'h12);
        temp_adc_host_i.put(1'b0, 8'hFF);
        temp_adc_host_i.fin();
        `CHK({pointer, hyst}, {8'h0A, 16'h12FF & SETP_MASK})
        wr(8'h03, 8'h34);
        `CHK(oti, 16'h3400)
        wr(8'h00, 8'h55);
        wr(8'h04, 8'h66);
        rd(8'h00);
        `CHK(hi, TEMP[15:8])
        rd(8'h01);
        `CHK(hi, 8'h20)
        ce_i = 1'b0;
        temp_adc_host_i.put(1'b1, 8'h03);
        `CHK(pointer, 8'h01)
        ce_i = 1'b1;
        temp_adc_host_i.fin();
        $display("t_regs finished");
    endtask : t_regs
    task automatic t_strobe();
        int n;
        int i;
        wr(8'h05, 8'h80);
        wait_idle();
        temp_adc_host_i.strobe();
        wait_hold(8);
        `CHK(channel, 3'h1)
        hold_len(n);
        `CHK(n, CONV_ADC_CYC)
        wait_idle();
        for (i = 0; i < 18000 && analog.busy === 1'b0; i++)
            @(negedge clk_i);
        `CHK(analog.busy, 1'b0)
        temp_adc_host_i.strobe();
        wait_hold(8);
        repeat (100) @(negedge clk_i);
        temp_adc_host_i.put(1'b1, 8'h05);
        `CHK(analog.hold, 1'b0)
        temp_adc_host_i.fin();
        wait_hold(400);
        hold_len(n);
        `CHK(n, CONV_ADC_CYC)
        $display("t_strobe finished");
    endtask : t_strobe
    initial
    begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        t_auto();
        t_regs();
        t_strobe();
        complete_run();
    end
endmodule : temp_adc_conversion_ptr_test
bind temp_adc_seq temp_adc_seq_chk temp_adc_seq_chk_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .convert_strobe_n_i(convert_strobe_n_i), .bus_active_i(bus_active_i), .bus_done_i(bus_done_i),
    .wr_byte_i(wr_byte_i), .analog_o(analog_o), .channel_o(channel_o), .pointer_o(pointer_o), .config_o(config_o));
`default_nettype wire

/* File: testbench/temp_adc_host.sv */
// Host model: decoded bus transfers and the converter core.
// Assumes design inputs change on falling clock edges.
`timescale 1ns/10ps
`default_nettype none
module temp_adc_host
    import temp_adc_pkg::*;
#(
    parameter logic [9:0] CODE = 10'h000
)
(
    // Clock
    input  wire logic        clk_i,
    // Design outputs
    input  wire analog_ctl_t analog_i,
    input  wire logic [7:0]  rd_data_i,
    // Design inputs
    output logic             bus_active_o = 1'b0,
    output logic             bus_done_o = 1'b0,
    output wr_byte_t         wr_byte_o = '0,
    output logic             rd_next_o = 1'b0,
    output logic             strobe_n_o = 1'b1,
    output logic             adc_valid_o = 1'b0,
    output logic [9:0]       adc_code_o = 10'h000
);
    logic [10:0] hold_cnt = 11'h000;
    // Core offers its code inside the shortest conversion
    always @(negedge clk_i)
    begin
        hold_cnt    <= analog_i.hold ? hold_cnt + 11'h001 : 11'h000;
        adc_valid_o <= analog_i.hold && hold_cnt == 11'h2BC;
        adc_code_o  <= (analog_i.hold && hold_cnt == 11'h2BC) ? CODE : ~adc_code_o;
    end
    task automatic put(input logic f, input logic [7:0] d);
        @(negedge clk_i);
        bus_active_o = 1'b1;
        wr_byte_o    = '{1'b1, f, d};
        @(negedge clk_i);
        wr_byte_o    = '{1'b0, 1'b0, ~d};
    endtask : put
    task automatic fin();
        @(negedge clk_i);
        bus_active_o = 1'b0;
        bus_done_o   = 1'b1;
        @(negedge clk_i);
        bus_done_o   = 1'b0;
    endtask : fin
    task automatic get(output logic [7:0] h, output logic [7:0] l);
        @(negedge clk_i);
        bus_active_o = 1'b1;
        repeat (2) @(negedge clk_i);
        h         = rd_data_i;
        rd_next_o = 1'b1;
        @(negedge clk_i);
        rd_next_o = 1'b0;
        @(negedge clk_i);
        l         = rd_data_i;
    endtask : get
    task automatic strobe();
        repeat (20) @(negedge clk_i);
        strobe_n_o = 1'b0;
        @(negedge clk_i);
        strobe_n_o = 1'b1;
    endtask : strobe
endmodule : temp_adc_host
`default_nettype wire

/* File: testbench/temp_adc_seq_chk.sv */
// Port checker for the conversion sequencer.
// Bound into temp_adc_seq from the testbench top file.
`timescale 1ns/10ps
`default_nettype none
module temp_adc_seq_chk
    import temp_adc_pkg::*;
(
    // Clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // Inputs
    input wire logic        convert_strobe_n_i,
    input wire logic        bus_active_i,
    input wire logic        bus_done_i,
    input wire wr_byte_t    wr_byte_i,
    // Outputs
    input wire analog_ctl_t analog_o,
    input wire logic [2:0]  channel_o,
    input wire logic [7:0]  pointer_o,
    input wire logic [7:0]  config_o
);
    logic        mode;
    logic        armed;
    logic [7:0]  cnt;
    logic [11:0] hold_len;
    logic        ptr_wr;
    logic        wr_data;
    logic        auto_done;
    assign ptr_wr    = ce_i && wr_byte_i.start && wr_byte_i.first;
    assign wr_data   = ce_i && wr_byte_i.start && !wr_byte_i.first;
    assign auto_done = ce_i && bus_done_i && !mode;
    // ========================================
    // Helper state: mode, wait counter, hold length
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mode     <= 1'b0;
            armed    <= 1'b0;
            cnt      <= 8'h00;
            hold_len <= 12'h000;
        end
        else
        begin
            if (wr_data && pointer_o[2:0] == ADDR_SECOND_CONFIGURATION)
                mode <= wr_byte_i.data[MODE_BIT];
            armed    <= auto_done || (armed && !bus_active_i && cnt != 8'h96);
            cnt      <= auto_done ? 8'h00 : cnt + {7'h00, cnt != 8'hFF};
            hold_len <= analog_o.hold ? hold_len + 12'h001 : 12'h000;
        end
    end
    // ========================================
    // Assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_strobe_fall;
        $fell(convert_strobe_n_i) && !bus_active_i && !analog_o.busy;
    endsequence
    sequence s_hold_soon;
        ##[1:8] analog_o.hold;
    endsequence
    a_ptr_load: assert property (ptr_wr |=> pointer_o == $past(wr_byte_i.data))
        else $error("pointer not loaded");
    a_ptr_keep: assert property (!ptr_wr |=> $stable(pointer_o))
        else $error("pointer changed");
    a_cfg_write: assert property (wr_data && pointer_o[2:0] == ADDR_CONFIG |=> config_o == $past(wr_byte_i.data))
        else $error("config not written");
    a_ro_skip: assert property (wr_data && pointer_o[1:0] == 2'h0 |=> $stable(config_o))
        else $error("read-only write landed");
    a_wait_hold: assert property (armed && cnt < 8'h96 |-> analog_o.busy && !analog_o.hold)
        else $error("early hold");
    a_hold_start: assert property (armed && cnt == 8'h96 |-> analog_o.hold)
        else $error("hold late");
    a_conv_len: assert property ($fell(analog_o.hold) && !bus_active_i && !$past(bus_active_i)
        |-> hold_len == (channel_o == CH_TEMP ? 12'(CONV_TEMP_CYC) : 12'(CONV_ADC_CYC)))
        else $error("conversion length");
    a_abort_conv: assert property (bus_active_i && analog_o.hold |=> !analog_o.hold)
        else $error("no abort");
    a_chan_sel: assert property ($rose(analog_o.hold) |-> channel_o == config_o[CH_LSB +: 3])
        else $error("wrong channel");
    a_ref_on: assert property ((analog_o.ref_on == analog_o.hold) && (!analog_o.hold || analog_o.busy))
        else $error("reference state");
    a_strobe_hold: assert property (s_strobe_fall |-> s_hold_soon)
        else $error("strobe ignored");
endmodule : temp_adc_seq_chk
`default_nettype wire
